// >>> verif/dram_ca_props.sv
/*
  Checker for the command/address link, watching the link signals only.
  Assumes it is instantiated beside the link, fed by name, on core_clk.
*/
`timescale 1ns/100ps
module dram_ca_props
  import dram_ca_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              reset_n,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BANK_W-1:0] bank,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              cke,
  input wire logic              strobe_t,
  input wire logic              strobe_c
);
  logic       cke_q;
  logic       otf_q;
  logic [3:0] rd_age_q;
  wire  [3:0] code     = {cs_n, ras_n, cas_n, we_n};
  // Gate high at two edges in a row means the far end is out of power-down
  wire        taken    = cke && cke_q && !cs_n;
  wire        rd_taken = taken && (code == CMD_RD);
  wire        rd_short = otf_q && !addr[BC_BIT];

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cke_q    <= 1'b0;
      otf_q    <= 1'b0;
      rd_age_q <= 4'hf;
    end
    else
    begin
      cke_q <= cke;
      if (taken && code == CMD_MRS && bank[1:0] == 2'h0)
        otf_q <= (addr[1:0] == BL_OTF);
      if (rd_taken)
        rd_age_q <= 4'h1;
      else if (rd_age_q != 4'hf)
        rd_age_q <= rd_age_q + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_four;
    strobe_t ##1 !strobe_t ##1 strobe_t ##1 !strobe_t;
  endsequence
  sequence s_quiet;
    !strobe_t && strobe_c;
  endsequence

  // The far end loads its beat counter at the sampling edge, so the first
  // strobe high is seen two edges after the read was taken
  property p_rd_start;
    rd_taken |=> s_quiet ##1 (strobe_t && !strobe_c);
  endproperty
  property p_rd_long;
    rd_taken && !rd_short |=> ##1 s_four ##1 s_four ##1 s_quiet;
  endproperty
  property p_rd_short;
    rd_taken && rd_short |=> ##1 s_four ##1 s_quiet;
  endproperty
  property p_pair_lo;
    strobe_t |-> !strobe_c;
  endproperty
  property p_pair_hi;
    !strobe_t |-> strobe_c;
  endproperty
  property p_strobe_src;
    strobe_t |-> rd_age_q inside {[4'h1:4'h8]};
  endproperty
  property p_cmd_pulse;
    !cs_n |=> cs_n;
  endproperty
  property p_addr_hold;
    !cs_n |-> $stable(addr) && $stable(bank);
  endproperty

  a_rd_start: assert property (p_rd_start)
    else $error("read strobe did not start");
  a_rd_long: assert property (p_rd_long)
    else $error("eight beat strobe wrong");
  a_rd_short: assert property (p_rd_short)
    else $error("four beat strobe wrong");
  a_pair_lo: assert property (p_pair_lo)
    else $error("strobe pair not complementary");
  a_pair_hi: assert property (p_pair_hi)
    else $error("strobe pair idle level wrong");
  a_strobe_src: assert property (p_strobe_src)
    else $error("strobe without a read");
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command held over one cycle");
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved with command");
endmodule

// >>> verif/dram_cmd_addr_ctrl_inputs_tb.sv
/*
  Bench driving the controller register port and checking the DRAM end.
  Assumes both ends share core_clk and reset_n; no random stimulus.
*/
`timescale 1ns/100ps
module dram_cmd_addr_ctrl_inputs_tb;
  import dram_ca_pkg::*;

  logic              core_clk;
  logic              reset_n;
  logic [3:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata_q;
  logic              cmd_valid_q;
  logic [3:0]        cmd_q;
  logic [BANK_W-1:0] bank_q;
  logic [ADDR_W-1:0] row_q;
  logic [ADDR_W-1:0] col_q;
  logic              auto_pre_q;
  logic              pre_all_q;
  logic              eight_beat_burst_q;
  logic              mr_wr_q;
  logic [1:0]        mr_sel_q;
  logic [NBANK-1:0]  open_banks_q;
  pwr_t              pwr_q;
  logic              term_on_q;
  logic              wr_beat_q;
  logic [DQ_W-1:0]   wr_data_q;
  logic [1:0]        wr_byte_en_q;
  int                n_mismatch;
  int                cmp_count;
  int                cycles;
  int                highs;
  logic [12:0]       mr_val [4] = '{13'h0001, 13'h0004, 13'h0000, 13'h0000};

  dram_ca_if link ();

  dram_ca_host u_dram_ca_host (.core_clk(core_clk), .reset_n(reset_n), .link(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q));

  dram_ca_dev u_dram_ca_dev (.core_clk(core_clk), .reset_n(reset_n), .link(link),
    .cmd_valid_q(cmd_valid_q), .cmd_q(cmd_q), .bank_q(bank_q), .row_q(row_q),
    .col_q(col_q), .auto_pre_q(auto_pre_q), .pre_all_q(pre_all_q),
    .eight_beat_burst_q(eight_beat_burst_q), .mr_wr_q(mr_wr_q), .mr_sel_q(mr_sel_q),
    .open_banks_q(open_banks_q), .pwr_q(pwr_q), .term_on_q(term_on_q),
    .wr_beat_q(wr_beat_q), .wr_data_q(wr_data_q), .wr_byte_en_q(wr_byte_en_q));

  dram_ca_props u_dram_ca_props (.core_clk(core_clk), .reset_n(reset_n),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .bank(link.bank), .addr(link.addr), .cke(link.cke),
    .strobe_t(link.strobe_t), .strobe_c(link.strobe_c));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A gap cycle after each strobe keeps link commands one cycle apart
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Returns in the cycle where the DRAM end shows its decode
  task automatic wr_seen(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    @(posedge core_clk);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask

  task automatic cmd(input logic [3:0] code, input logic [2:0] b, input logic [12:0] a);
    wr(REG_ADDR, {13'h0, b, 3'h0, a});
    wr_seen(REG_CMD, {28'h0, code});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial
  begin
    reset_n    = 1'b0;
    reg_addr   = 4'h0;
    reg_wdata  = 32'h0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    n_mismatch = 0;
    cmp_count  = 0;
    cycles     = 0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(REG_STATUS, 32'h0000_0002);
    rd(4'h7, 32'h0);
    chk({pwr_q, eight_beat_burst_q, cmd_q}, {PWR_PRE_PDN, 1'b1, 4'hf});
    cmd(CMD_ACT, 3'h5, 13'h1abc);
    chk({cmd_valid_q, open_banks_q}, 9'h000);
    wr_seen(REG_CTRL, 32'h1);
    chk(pwr_q, PWR_ACTIVE);
    cmd(CMD_ACT, 3'h5, 13'h1abc);
    chk({cmd_valid_q, cmd_q, bank_q}, {1'b1, CMD_ACT, 3'h5});
    chk({row_q, open_banks_q}, {13'h1abc, 8'h20});
    cmd(4'hb, 3'h2, 13'h0);
    chk({cmd_valid_q, cmd_q, open_banks_q}, {1'b0, 4'hf, 8'h20});
    wr_seen(REG_CTRL, 32'h0);
    chk(pwr_q, PWR_ACT_PDN);
    wr_seen(REG_CTRL, 32'h1);
    chk(pwr_q, PWR_ACTIVE);
    cmd(CMD_WR, 3'h5, 13'h1404);
    chk({col_q, bank_q}, {13'h1004, 3'h5});
    chk({auto_pre_q, eight_beat_burst_q}, 2'h3);
    for (int i = 0; i < 9; i++)
    begin
      wr_seen(REG_WDATA, {14'h0, i[1:0], 12'h0a5, i[3:0]});
      chk(wr_beat_q, i < 8);
      if (i < 8)
        chk({wr_byte_en_q, wr_data_q}, {~i[1:0], 12'h0a5, i[3:0]});
    end
    cmd(CMD_ACT, 3'h1, 13'h0);
    cmd(CMD_ACT, 3'h2, 13'h0);
    chk(open_banks_q, 8'h06);
    cmd(CMD_PRE, 3'h1, 13'h0);
    chk({pre_all_q, open_banks_q}, 9'h004);
    cmd(CMD_PRE, 3'h0, 13'h0400);
    chk({pre_all_q, open_banks_q}, 9'h100);
    wr_seen(REG_CTRL, 32'h3);
    chk(term_on_q, 1'b0);
    for (int m = 3; m >= 0; m--)
    begin
      cmd(CMD_MRS, 3'(m), mr_val[m]);
      chk({mr_wr_q, mr_sel_q}, {1'b1, 2'(m)});
    end
    chk(term_on_q, 1'b1);
    wr_seen(REG_CTRL, 32'h1);
    chk(term_on_q, 1'b0);
    wr_seen(REG_CTRL, 32'h3);
    chk(term_on_q, 1'b1);
    wr_seen(REG_CMD, (32'h1 << SR_BIT) | {28'h0, CMD_REF});
    chk({cmd_valid_q, pwr_q}, {1'b0, PWR_SELF_REF});
    @(posedge core_clk);
    #1;
    chk(term_on_q, 1'b0);
    wr_seen(REG_CTRL, 32'h1);
    chk(pwr_q, PWR_ACTIVE);
    cmd(CMD_ACT, 3'h0, 13'h0);
    for (int k = 0; k < 2; k++)
    begin
      cmd(CMD_RD, 3'h0, (k == 0) ? 13'h1000 : 13'h0000);
      chk(eight_beat_burst_q, k == 0);
      highs = 0;
      repeat (10)
      begin
        highs += link.strobe_t;
        @(posedge core_clk);
        #1;
      end
      chk(highs, (k == 0) ? 4 : 2);
    end
    @(posedge core_clk);
    reset_n <= 1'b0;
    #1;
    chk({open_banks_q, pwr_q}, {8'h00, PWR_ACTIVE});
    @(posedge core_clk);
    reset_n <= 1'b1;
    rd(REG_STATUS, 32'h0000_0002);
    report_and_stop();
  end
endmodule

// >>> verilog/dram_ca_dev.sv
/*
  DRAM end of the command/address link: decodes commands, tracks open banks,
  holds the mode-setting registers, gates power-down, termination and writes.
  Assumes the controller drives the link from flops on the same core_clk.
*/
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
module dram_ca_dev
  import dram_ca_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  dram_ca_if.dev                 link,
  output logic                   cmd_valid_q,
  output logic [3:0]             cmd_q,
  output logic [BANK_W-1:0]      bank_q,
  output logic [ADDR_W-1:0]      row_q,
  output logic [ADDR_W-1:0]      col_q,
  output logic                   auto_pre_q,
  output logic                   pre_all_q,
  output logic                   eight_beat_burst_q,
  output logic                   mr_wr_q,
  output logic [1:0]             mr_sel_q,
  output logic [NBANK-1:0]       open_banks_q,
  output pwr_t                   pwr_q,
  output logic                   term_on_q,
  output logic                   wr_beat_q,
  output logic [DQ_W-1:0]        wr_data_q,
  output logic [1:0]             wr_byte_en_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Input gating and command decode

  logic [ADDR_W-1:0] mode_setting_reg [NMR];
  logic [CNT_W-1:0]  wr_left_q;
  logic [CNT_W-1:0]  rd_left_q;
  logic              strobe_t_q;
  logic              strobe_c_q;

  wire        ca_buf_on  = (pwr_q == PWR_ACTIVE);
  wire [3:0]  raw_cmd    = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  wire        cmd_take   = ca_buf_on && link.cke && !link.cs_n;
  wire [3:0]  cmd_dec    = cmd_take ? raw_cmd : CMD_DES;
  wire        is_act     = (cmd_dec == CMD_ACT);
  wire        is_pre     = (cmd_dec == CMD_PRE);
  wire        is_mrs     = (cmd_dec == CMD_MRS);
  wire        is_wr      = (cmd_dec == CMD_WR);
  wire        is_rd      = (cmd_dec == CMD_RD);
  wire        is_col     = is_column(cmd_dec);
  wire        ap_bit     = link.addr[AP_BIT];
  wire [NBANK-1:0] bank_bit = NBANK'(1) << link.bank;

  // Bit ten of a column address is the precharge request, not an address
  wire [ADDR_W-1:0] col_addr = link.addr & ~(ADDR_W'(1) << AP_BIT);

  wire        otf_on     = (mode_setting_reg[MR_BURST][BL_LSB+:2] == BL_OTF);
  wire        burst_eight = !otf_on || link.addr[BC_BIT];
  wire [CNT_W-1:0] beats = burst_eight ? BEATS_BL8 : BEATS_BC4;

  ////////////////////////////////////////////////////////////////////////////
  // Bank state

  wire [NBANK-1:0] close_mask =
    (is_pre && ap_bit)               ? {NBANK{1'b1}} :
    (is_pre || (is_col && ap_bit))   ? bank_bit      : {NBANK{1'b0}};
  wire [NBANK-1:0] open_banks_d =
    (open_banks_q & ~close_mask) | (is_act ? bank_bit : {NBANK{1'b0}});

  ////////////////////////////////////////////////////////////////////////////
  // Power state; entry and both exits act on the link clock gate level at each edge;
  // self-refresh exit is the same as power-down exit, with no command qualification

  pwr_t pwr_d;
  wire  sr_entry = ca_buf_on && !link.cs_n && (raw_cmd == CMD_REF);

  always_comb
  begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_ACTIVE:
      begin
        if (!link.cke)
        begin
          if (sr_entry)
            pwr_d = PWR_SELF_REF;
          else if (open_banks_q == {NBANK{1'b0}})
            pwr_d = PWR_PRE_PDN;
          else
            pwr_d = PWR_ACT_PDN;
        end
      end
      PWR_PRE_PDN,
      PWR_ACT_PDN:
      begin
        if (link.cke)
          pwr_d = PWR_ACTIVE;
      end
      PWR_SELF_REF:
      begin
        if (link.cke)
          pwr_d = PWR_ACTIVE;
      end
      default:
        pwr_d = PWR_ACTIVE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination: disabled in the mode register means the pin is not looked at.
  // One enable covers all sixteen data lines, both strobe pairs and both masks;
  // this width has no termination strobe.

  wire term_cfg = mode_setting_reg[MR_TERM][TERM_EN_BIT];
  wire term_on_d = term_cfg && link.termination_control
                   && (pwr_q != PWR_SELF_REF);

  ////////////////////////////////////////////////////////////////////////////
  // Write beats and read strobe

  wire        beat_ok   = (wr_left_q != '0) && link.wr_beat && ca_buf_on;
  wire [1:0]  byte_en_d = {!link.high_byte_write_mask,
                           !link.low_byte_write_mask};
  wire        rd_run    = (rd_left_q != '0);

  assign link.strobe_t = strobe_t_q;
  assign link.strobe_c = strobe_c_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers, all on the rising clock crossing

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_valid_q        <= 1'b0;
      cmd_q              <= CMD_DES;
      bank_q             <= '0;
      row_q              <= '0;
      col_q              <= '0;
      auto_pre_q         <= 1'b0;
      pre_all_q          <= 1'b0;
      eight_beat_burst_q <= 1'b1;
      open_banks_q       <= '0;
      pwr_q              <= PWR_ACTIVE;
      term_on_q          <= 1'b0;
    end
    else
    begin
      cmd_valid_q  <= (cmd_dec != CMD_DES) && (cmd_dec != CMD_NOP);
      cmd_q        <= cmd_dec;
      open_banks_q <= open_banks_d;
      pwr_q        <= pwr_d;
      term_on_q    <= term_on_d;
      pre_all_q    <= is_pre && ap_bit;
      auto_pre_q   <= is_col && ap_bit;
      if (is_act || is_pre || is_col)
        bank_q <= link.bank;
      if (is_act)
        row_q <= link.addr;
      if (is_col)
      begin
        col_q              <= col_addr;
        eight_beat_burst_q <= burst_eight;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mr_wr_q  <= 1'b0;
      mr_sel_q <= '0;
      for (int i = 0; i < NMR; i++)
        mode_setting_reg[i] <= MR_RESET;
    end
    else
    begin
      mr_wr_q <= is_mrs;
      if (is_mrs)
      begin
        mr_sel_q                          <= link.bank[1:0];
        mode_setting_reg[link.bank[1:0]]  <= link.addr;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_left_q    <= '0;
      wr_beat_q    <= 1'b0;
      wr_data_q    <= '0;
      wr_byte_en_q <= '0;
    end
    else
    begin
      wr_beat_q <= beat_ok;
      if (beat_ok)
      begin
        wr_data_q    <= link.wr_data;
        wr_byte_en_q <= byte_en_d;
      end
      if (is_wr)
        wr_left_q <= beats;
      else if (beat_ok)
        wr_left_q <= wr_left_q - CNT_W'(1);
    end
  end

  // Strobe toggles once per clock during a read burst and parks low
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_left_q  <= '0;
      strobe_t_q <= 1'b0;
      strobe_c_q <= 1'b1;
    end
    else
    begin
      if (is_rd)
        rd_left_q <= beats;
      else if (rd_run)
        rd_left_q <= rd_left_q - CNT_W'(1);
      strobe_t_q <= rd_run ? !strobe_t_q : 1'b0;
      strobe_c_q <= rd_run ? strobe_t_q : 1'b1;
    end
  end

endmodule

// >>> verilog/dram_ca_host.sv
/*
  Controller end of the command/address link: software writes address, control
  and command registers; each command write puts one command on the link.
  Assumes a plain register port with read data one cycle after the strobe.
*/
`timescale 1ns/100ps
module dram_ca_host
  import dram_ca_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  dram_ca_if.host           link,
  input  wire logic [3:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata_q
);

  logic [3:0]        cmd_out_q;
  logic [BANK_W-1:0] bank_q;
  logic [ADDR_W-1:0] addr_q;
  logic              cke_q;
  logic              term_q;
  logic [DQ_W-1:0]   wdata_q;
  logic [1:0]        mask_q;
  logic              beat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire wr_cmd   = reg_wr && (reg_addr == REG_CMD);
  wire wr_addr  = reg_wr && (reg_addr == REG_ADDR);
  wire wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
  wire wr_wdata = reg_wr && (reg_addr == REG_WDATA);
  // Self refresh needs the gate low in the very cycle of the refresh command,
  // which two separate register writes can never line up
  wire sr_go    = wr_cmd && reg_wdata[SR_BIT];

  wire [31:0] addr_word = {13'h0000, bank_q, 3'h0, addr_q};
  wire [31:0] ctrl_word = {30'h00000000, term_q, cke_q};
  wire [31:0] stat_word = {30'h00000000, link.strobe_c, link.strobe_t};
  wire [31:0] rdata_d =
    (reg_addr == REG_ADDR)   ? addr_word :
    (reg_addr == REG_CTRL)   ? ctrl_word :
    (reg_addr == REG_STATUS) ? stat_word : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Link drive

  assign link.cs_n                 = cmd_out_q[3];
  assign link.ras_n                = cmd_out_q[2];
  assign link.cas_n                = cmd_out_q[1];
  assign link.we_n                 = cmd_out_q[0];
  assign link.bank                 = bank_q;
  assign link.addr                 = addr_q;
  assign link.cke                  = cke_q;
  assign link.termination_control = term_q;
  assign link.wr_data              = wdata_q;
  assign link.low_byte_write_mask  = mask_q[0];
  assign link.high_byte_write_mask = mask_q[1];
  assign link.wr_beat              = beat_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_out_q   <= CMD_DES;
      bank_q      <= '0;
      addr_q      <= '0;
      cke_q       <= 1'b0;
      term_q      <= 1'b0;
      wdata_q     <= '0;
      mask_q      <= '0;
      beat_q      <= 1'b0;
      reg_rdata_q <= '0;
    end
    else
    begin
      // A command lasts one cycle, then the link returns to deselect
      cmd_out_q <= wr_cmd ? reg_wdata[3:0] : CMD_DES;
      beat_q    <= wr_wdata;
      if (wr_addr)
      begin
        addr_q <= reg_wdata[ADDR_W-1:0];
        bank_q <= reg_wdata[BANK_LSB+:BANK_W];
      end
      if (wr_ctrl)
      begin
        cke_q  <= reg_wdata[CKE_BIT];
        term_q <= reg_wdata[TERM_BIT];
      end
      else if (sr_go)
        cke_q  <= 1'b0;
      if (wr_wdata)
      begin
        wdata_q <= reg_wdata[DQ_W-1:0];
        mask_q  <= {reg_wdata[HMASK_BIT], reg_wdata[LMASK_BIT]};
      end
      reg_rdata_q <= reg_rd ? rdata_d : 32'h00000000;
    end
  end

endmodule

// >>> verilog/dram_ca_if.sv
/*
  Link between the memory controller and the DRAM command/address front end.
  Assumes both ends run on the same core clock; no clocking block.
*/
`timescale 1ns/100ps
interface dram_ca_if;
  import dram_ca_pkg::*;

  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  logic [BANK_W-1:0]   bank;
  logic [ADDR_W-1:0]   addr;
  logic                cke;
  logic                termination_control;
  logic [DQ_W-1:0]     wr_data;
  logic                low_byte_write_mask;
  logic                high_byte_write_mask;
  logic                wr_beat;
  logic                strobe_t;
  logic                strobe_c;

  modport dev (
    input  cs_n, ras_n, cas_n, we_n, bank, addr, cke, termination_control,
    input  wr_data, low_byte_write_mask, high_byte_write_mask, wr_beat,
    output strobe_t, strobe_c
  );

  modport host (
    output cs_n, ras_n, cas_n, we_n, bank, addr, cke, termination_control,
    output wr_data, low_byte_write_mask, high_byte_write_mask, wr_beat,
    input  strobe_t, strobe_c
  );
endinterface

// >>> verilog/dram_ca_pkg.sv
/*
  Shared constants for the DRAM command/address link: widths, command codes,
  mode-setting field positions, burst lengths, power states and controller
  register offsets.
  Assumes both link ends and the bench import it whole.
*/
package dram_ca_pkg;

  localparam int ADDR_W = 13;
  localparam int BANK_W = 3;
  localparam int NBANK  = 8;
  localparam int DQ_W   = 16;
  localparam int NMR    = 4;
  localparam int CNT_W  = 4;

  // Command codes as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_ZQ  = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DES = 4'hf;

  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  // Mode-setting register layout
  localparam int         MR_BURST    = 0;
  localparam int         MR_TERM     = 1;
  localparam int         BL_LSB      = 0;
  localparam logic [1:0] BL_OTF      = 2'h1;
  localparam int         TERM_EN_BIT = 2;
  localparam logic [ADDR_W-1:0] MR_RESET = 13'h0000;

  localparam logic [CNT_W-1:0] BEATS_BL8 = 4'h8;
  localparam logic [CNT_W-1:0] BEATS_BC4 = 4'h4;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_PRE_PDN, PWR_ACT_PDN, PWR_SELF_REF} pwr_t;

  // Controller register word indices
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_CTRL   = 4'h2;
  localparam logic [3:0] REG_WDATA  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int BANK_LSB  = 16;
  localparam int CKE_BIT   = 0;
  localparam int TERM_BIT  = 1;
  localparam int LMASK_BIT = 16;
  localparam int HMASK_BIT = 17;
  localparam int SR_BIT    = 4;

  function automatic logic is_column(input logic [3:0] c);
    is_column = (c == CMD_WR) || (c == CMD_RD);
  endfunction

endpackage
